/* rtl/iaf_core.sv */
// Purpose: indirect address generation and alu flag logic
// Assumes: requests from the execution unit are one-cycle pulses
// Notes:   memory strobes and address come out one cycle later
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "iaf_cfg.svh"
module iaf_core (
	input  wire logic                 core_clk,      // core clock
	input  wire logic                 rst,           // sync reset, high
	input  wire logic [`IAF_REG_AW-1:0] reg_addr,    // register offset
	input  wire logic [`IAF_DATA_W-1:0] reg_wdata,   // register write data
	input  wire logic                 reg_wr,        // register write strobe
	input  wire logic                 reg_rd,        // register read strobe
	output logic [`IAF_DATA_W-1:0]    reg_rdata,     // read data, next cycle
	input  wire logic                 ind_req,       // indirect access pulse
	input  wire logic [1:0]           ind_sel,       // pointer number
	input  wire iaf_pkg::iaf_mode_t   ind_mode,      // access flavour
	input  wire logic                 ind_wr,        // 1 write, 0 read
	input  wire logic [`IAF_DATA_W-1:0] ind_wdata,   // indirect write data
	output logic [`IAF_ADDR_W-1:0]    mem_addr,      // data memory address
	output logic                      mem_re,        // memory read strobe
	output logic                      mem_we,        // memory write strobe
	output logic [`IAF_DATA_W-1:0]    mem_wdata,     // memory write data
	output logic                      ind_null,      // virtual access seen
	input  wire logic                 alu_go,        // alu op pulse
	input  wire iaf_pkg::iaf_op_t     alu_op,        // alu operation
	input  wire logic [`IAF_DATA_W-1:0] alu_a,       // source operand
	input  wire logic [`IAF_DATA_W-1:0] alu_b,       // second operand
	input  wire logic                 alu_to_status, // result targets status
	output logic [`IAF_DATA_W-1:0]    alu_result,    // registered result
	output logic [`IAF_FLAG_W-1:0]    alu_flags      // live flag register
);
	import iaf_pkg::*;

	// adder returning {carry, digit carry, overflow, sum}
	function automatic logic [10:0] iaf_addc(input iaf_byte_t a,
		input iaf_byte_t b, input logic cin);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		return {s[8], h[4], (a[7] == b[7]) && (s[7] != a[7]), s[7:0]};
	endfunction : iaf_addc

	// flags that each operation is allowed to change, N OV Z DC C
	function automatic iaf_flags_t iaf_op_mask(input iaf_op_t op);
		case (op)
			IAF_OP_ADD, IAF_OP_SUB:   return 5'h1F;
			IAF_OP_RRC, IAF_OP_RLC:   return 5'h17;
			IAF_OP_RRNC, IAF_OP_RLNC: return 5'h16;
			IAF_OP_CLR:               return 5'h04;
			default:                  return 5'h14;
		endcase
	endfunction : iaf_op_mask

	// true when an address lies inside a decoded window
	function automatic logic iaf_in_range(input iaf_addr_t a,
		input iaf_addr_t lo, input iaf_addr_t hi);
		return (a >= lo) && (a <= hi);
	endfunction : iaf_in_range

	iaf_core_if cif ();

	// pointer steps and byte writes resolve inside the unit
	iaf_ptr_unit u_ptr (
		.core_clk (core_clk),
		.rst      (rst),
		.pif      (cif.ptr)
	);

	// flag unit: alu update beats a software status write
	iaf_flag_unit u_flg (
		.core_clk (core_clk),
		.rst      (rst),
		.fif      (cif.flg)
	);

	// working register and bus read data
	iaf_byte_t working_reg_q;
	iaf_byte_t working_reg_d;
	iaf_byte_t rdata_q;
	iaf_byte_t rdata_d;

	// indirect access state
	iaf_addr_t  base;
	iaf_addr_t  eff;
	logic       is_virt;
	logic       is_ptrb;
	logic [2:0] ptrb_idx;
	// decoded request kinds
	logic       ptrb_wr;
	logic       virt_rd;
	iaf_addr_t  maddr_q;
	iaf_addr_t  maddr_d;
	logic       mre_q;
	logic       mre_d;
	logic       mwe_q;
	logic       mwe_d;
	iaf_byte_t  mwd_q;
	iaf_byte_t  mwd_d;
	logic       null_q;
	logic       null_d;

	// alu state
	iaf_byte_t  res;
	iaf_flags_t fl;
	logic [10:0] sum;
	iaf_byte_t  res_q;
	iaf_byte_t  res_d;
	logic       cin;

	// effective address and pointer side effects
	always_comb begin
		base = cif.ptr_val[ind_sel];
		eff = base;
		// indexed and pre-increment both need the adder
		case (ind_mode)
			IAF_M_INC_BEFORE: eff = iaf_ptr_add(base, `IAF_STEP_INC);
			IAF_M_INDEXED:    eff = iaf_ptr_add(base, working_reg_q);
			default:          eff = base;
		endcase
		is_virt = iaf_in_range(eff, `IAF_VIRT_LO, `IAF_VIRT_HI);
		is_ptrb = iaf_in_range(eff, `IAF_PTRB_LO, `IAF_PTRB_HI);
		ptrb_idx = 3'(eff - `IAF_PTRB_LO);
		ptrb_wr = ind_req && ind_wr && is_ptrb;
		virt_rd = ind_req && !ind_wr && is_virt;
		cif.mod_en = ind_req && (ind_mode == IAF_M_DEC_AFTER
			|| ind_mode == IAF_M_INC_AFTER
			|| ind_mode == IAF_M_INC_BEFORE);
		cif.mod_sel = ind_sel;
		cif.mod_dec = (ind_mode == IAF_M_DEC_AFTER);
		// indirect pointer byte write first, then the register port
		cif.pw_en = 1'b0;
		cif.pw_idx = 3'h0;
		cif.pw_data = ind_wdata;
		if (ptrb_wr) begin
			cif.pw_en = 1'b1;
			cif.pw_idx = ptrb_idx;
		end else if (reg_wr && reg_addr <= `IAF_OFS_PTR2H) begin
			cif.pw_en = 1'b1;
			cif.pw_idx = reg_addr[2:0];
			cif.pw_data = reg_wdata;
		end
		// strobes out of the pointer side reach the flags only through a virtual read, which sets Z
		// a pointer byte write stays inside, memory never sees it
		maddr_d = maddr_q;
		mre_d = 1'b0;
		mwe_d = 1'b0;
		mwd_d = mwd_q;
		null_d = 1'b0;
		if (ind_req) begin
			maddr_d = eff;
			mwd_d = ind_wdata;
			null_d = is_virt;
			mre_d = !ind_wr && !is_virt;
			mwe_d = ind_wr && !is_virt && !is_ptrb;
		end
		cif.fl_z_set = virt_rd;
	end

	// alu result and flags
	always_comb begin
		// rotate through carry uses the carry as it stands now
		cin = cif.fl_val[`IAF_FB_C];
		sum = iaf_addc(alu_a, alu_b, 1'b0);
		res = alu_a;
		fl = 5'h00;
		case (alu_op)
			IAF_OP_ADD: begin
				sum = iaf_addc(alu_a, alu_b, 1'b0);
				res = sum[7:0];
			end
			IAF_OP_SUB: begin
				sum = iaf_addc(alu_a, ~alu_b, 1'b1);
				res = sum[7:0];
			end
			IAF_OP_AND: res = alu_a & alu_b;
			IAF_OP_OR:  res = alu_a | alu_b;
			IAF_OP_XOR: res = alu_a ^ alu_b;
			IAF_OP_CLR: res = `IAF_BYTE_ZERO;
			IAF_OP_RRC: begin
				res = {cin, alu_a[7:1]};
				fl[`IAF_FB_C] = alu_a[0];
				fl[`IAF_FB_DC] = alu_a[4];
			end
			IAF_OP_RLC: begin
				res = {alu_a[6:0], cin};
				fl[`IAF_FB_C] = alu_a[7];
				fl[`IAF_FB_DC] = alu_a[3];
			end
			IAF_OP_RRNC: begin
				res = {alu_a[0], alu_a[7:1]};
				fl[`IAF_FB_DC] = alu_a[4];
			end
			IAF_OP_RLNC: begin
				res = {alu_a[6:0], alu_a[7]};
				fl[`IAF_FB_DC] = alu_a[3];
			end
			default: res = alu_a;
		endcase
		// only add and subtract touch overflow
		if (alu_op == IAF_OP_ADD || alu_op == IAF_OP_SUB) begin
			fl[`IAF_FB_C] = sum[10];
			fl[`IAF_FB_DC] = sum[9];
			fl[`IAF_FB_OV] = sum[8];
		end
		fl[`IAF_FB_N] = res[7];
		fl[`IAF_FB_Z] = (res == `IAF_BYTE_ZERO);
		cif.fl_alu_en = alu_go;
		cif.fl_to_status = alu_to_status;
		cif.fl_alu = fl;
		cif.fl_mask = iaf_op_mask(alu_op);
		cif.fl_result = res;
		cif.fl_sw_en = reg_wr && reg_addr == `IAF_OFS_STATUS;
		cif.fl_sw_data = reg_wdata[`IAF_FLAG_W-1:0];
		res_d = alu_go ? res : res_q;
	end

	// register port
	always_comb begin
		working_reg_d = working_reg_q;
		if (reg_wr && reg_addr == `IAF_OFS_WORKING_REG) begin
			working_reg_d = reg_wdata;
		end
		// unread offsets return zero so software sees no stale byte
		rdata_d = `IAF_BYTE_ZERO;
		if (reg_rd) begin
			case (reg_addr)
				`IAF_OFS_PTR0L, `IAF_OFS_PTR1L, `IAF_OFS_PTR2L: begin
					rdata_d = cif.ptr_val[reg_addr[2:1]][7:0];
				end
				`IAF_OFS_PTR0H, `IAF_OFS_PTR1H, `IAF_OFS_PTR2H: begin
					rdata_d = {4'h0, cif.ptr_val[reg_addr[2:1]][11:8]};
				end
				`IAF_OFS_WORKING_REG:   rdata_d = working_reg_q;
				`IAF_OFS_STATUS: rdata_d = {3'b000, cif.fl_val};
				`IAF_OFS_MADDRL: rdata_d = maddr_q[7:0];
				`IAF_OFS_MADDRH: rdata_d = {4'h0, maddr_q[11:8]};
				`IAF_OFS_ALURES: rdata_d = res_q;
				default:         rdata_d = `IAF_BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			working_reg_q  <= `IAF_WORKING_REG_RST;
			rdata_q <= `IAF_BYTE_ZERO;
			maddr_q <= `IAF_PTR_RST;
			mre_q   <= 1'b0;
			mwe_q   <= 1'b0;
			mwd_q   <= `IAF_BYTE_ZERO;
			null_q  <= 1'b0;
			res_q   <= `IAF_BYTE_ZERO;
		end else begin
			working_reg_q  <= working_reg_d;
			rdata_q <= rdata_d;
			maddr_q <= maddr_d;
			mre_q   <= mre_d;
			mwe_q   <= mwe_d;
			mwd_q   <= mwd_d;
			null_q  <= null_d;
			res_q   <= res_d;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata  = rdata_q;
	assign mem_addr   = maddr_q;
	assign mem_re     = mre_q;
	assign mem_we     = mwe_q;
	assign mem_wdata  = mwd_q;
	assign ind_null   = null_q;
	assign alu_result = res_q;
	assign alu_flags  = cif.fl_val;
endmodule : iaf_core

/* rtl/iaf_cfg.svh */
// Purpose: constants for the indirect address and alu flag block
// Assumes: 8-bit data path, 12-bit data address space
// Notes:   register offsets are on the plain register port
`ifndef IAF_CFG_SVH
`define IAF_CFG_SVH

`define IAF_DATA_W      8
`define IAF_ADDR_W      12
`define IAF_REG_AW      4
`define IAF_FLAG_W      5
`define IAF_HI_W        4

// register port offsets
`define IAF_OFS_PTR0L   4'h0
`define IAF_OFS_PTR0H   4'h1
`define IAF_OFS_PTR1L   4'h2
`define IAF_OFS_PTR1H   4'h3
`define IAF_OFS_PTR2L   4'h4
`define IAF_OFS_PTR2H   4'h5
`define IAF_OFS_WORKING_REG    4'h6
`define IAF_OFS_STATUS  4'h7
`define IAF_OFS_MADDRL  4'h8
`define IAF_OFS_MADDRH  4'h9
`define IAF_OFS_ALURES  4'hA

// flag bit positions inside alu_flags
`define IAF_FB_N        4
`define IAF_FB_OV       3
`define IAF_FB_Z        2
`define IAF_FB_DC       1
`define IAF_FB_C        0

// data space locations decoded by the pointer logic
`define IAF_VIRT_LO     12'hFE0
`define IAF_VIRT_HI     12'hFEE
`define IAF_PTRB_LO     12'hFD8
`define IAF_PTRB_HI     12'hFDD

// reset values
`define IAF_PTR_RST     12'h000
`define IAF_WORKING_REG_RST    8'h00
`define IAF_FLAG_RST    5'h00
`define IAF_BYTE_ZERO   8'h00

// pointer steps
`define IAF_STEP_INC    8'h01
`define IAF_STEP_DEC    8'hFF

`endif

/* rtl/iaf_pkg.sv */
// Purpose: types and shared arithmetic of the pointer and flag block
// Assumes: iaf_cfg.svh supplies widths
// Notes:   pointer arithmetic wraps in the 12-bit space
`include "iaf_cfg.svh"
package iaf_pkg;

	typedef enum logic [2:0] {
		IAF_M_PLAIN      = 3'b000,
		IAF_M_DEC_AFTER  = 3'b001,
		IAF_M_INC_AFTER  = 3'b010,
		IAF_M_INC_BEFORE = 3'b011,
		IAF_M_INDEXED    = 3'b100
	} iaf_mode_t;

	typedef enum logic [3:0] {
		IAF_OP_ADD  = 4'b0000,
		IAF_OP_SUB  = 4'b0001,
		IAF_OP_AND  = 4'b0010,
		IAF_OP_OR   = 4'b0011,
		IAF_OP_XOR  = 4'b0100,
		IAF_OP_MOV  = 4'b0101,
		IAF_OP_CLR  = 4'b0110,
		IAF_OP_RRC  = 4'b0111,
		IAF_OP_RLC  = 4'b1000,
		IAF_OP_RRNC = 4'b1001,
		IAF_OP_RLNC = 4'b1010
	} iaf_op_t;

	typedef logic [`IAF_ADDR_W-1:0] iaf_addr_t;
	typedef logic [`IAF_DATA_W-1:0] iaf_byte_t;
	typedef logic [`IAF_FLAG_W-1:0] iaf_flags_t;

	// pointer plus signed byte, full 12-bit carry, wraps
	function automatic iaf_addr_t iaf_ptr_add(input iaf_addr_t p,
		input iaf_byte_t off);
		iaf_addr_t ext;
		ext = {{(`IAF_ADDR_W-`IAF_DATA_W){off[`IAF_DATA_W-1]}}, off};
		return p + ext;
	endfunction : iaf_ptr_add

endpackage : iaf_pkg

/* rtl/iaf_core_if.sv */
// Purpose: links between the top and its pointer and flag units
// Assumes: one clock, signals valid for one cycle
// Notes:   top drives requests, units return state
`timescale 1ns/1ps
`include "iaf_cfg.svh"
interface iaf_core_if;
	import iaf_pkg::*;

	iaf_addr_t  ptr_val [3];
	logic       pw_en;
	logic [2:0] pw_idx;
	iaf_byte_t  pw_data;
	logic       mod_en;
	logic [1:0] mod_sel;
	logic       mod_dec;

	logic       fl_alu_en;
	logic       fl_to_status;
	iaf_flags_t fl_alu;
	iaf_flags_t fl_mask;
	iaf_byte_t  fl_result;
	logic       fl_sw_en;
	iaf_flags_t fl_sw_data;
	logic       fl_z_set;
	iaf_flags_t fl_val;

	modport top (input ptr_val, fl_val, output pw_en, pw_idx, pw_data,
		mod_en, mod_sel, mod_dec, fl_alu_en, fl_to_status, fl_alu,
		fl_mask, fl_result, fl_sw_en, fl_sw_data, fl_z_set);
	modport ptr (output ptr_val, input pw_en, pw_idx, pw_data, mod_en,
		mod_sel, mod_dec);
	modport flg (output fl_val, input fl_alu_en, fl_to_status, fl_alu,
		fl_mask, fl_result, fl_sw_en, fl_sw_data, fl_z_set);
endinterface : iaf_core_if

/* rtl/iaf_ptr_unit.sv */
// Purpose: three 12-bit pointer registers with auto step
// Assumes: byte write and step requests come from the top
// Notes:   a byte write to a pointer cancels its step
`timescale 1ns/1ps
`include "iaf_cfg.svh"
module iaf_ptr_unit (
	input wire logic core_clk, // core clock
	input wire logic rst,      // sync reset, high
	iaf_core_if.ptr  pif       // pointer link
);
	import iaf_pkg::*;

	iaf_addr_t ptr_q [3];
	iaf_addr_t ptr_d [3];
	logic      step_ok;

	always_comb begin
		ptr_d = ptr_q;
		step_ok = !(pif.pw_en && pif.pw_idx[2:1] == pif.mod_sel);
		if (pif.mod_en && step_ok) begin
			ptr_d[pif.mod_sel] = iaf_ptr_add(ptr_q[pif.mod_sel],
				pif.mod_dec ? `IAF_STEP_DEC : `IAF_STEP_INC);
		end
		if (pif.pw_en) begin
			if (pif.pw_idx[0]) begin
				ptr_d[pif.pw_idx[2:1]][`IAF_ADDR_W-1:`IAF_DATA_W] =
					pif.pw_data[`IAF_HI_W-1:0];
			end else begin
				ptr_d[pif.pw_idx[2:1]][`IAF_DATA_W-1:0] = pif.pw_data;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ptr_q[0] <= `IAF_PTR_RST;
			ptr_q[1] <= `IAF_PTR_RST;
			ptr_q[2] <= `IAF_PTR_RST;
		end else begin
			ptr_q <= ptr_d;
		end
	end

	assign pif.ptr_val = ptr_q;
endmodule : iaf_ptr_unit

/* rtl/iaf_flag_unit.sv */
// Purpose: five-bit alu flag register with write masking
// Assumes: alu flags and mask are computed by the top
// Notes:   an alu update wins over a software write
`timescale 1ns/1ps
`include "iaf_cfg.svh"
module iaf_flag_unit (
	input wire logic core_clk, // core clock
	input wire logic rst,      // sync reset, high
	iaf_core_if.flg  fif       // flag link
);
	import iaf_pkg::*;

	iaf_flags_t flags_q;
	iaf_flags_t flags_d;

	always_comb begin
		flags_d = flags_q;
		if (fif.fl_alu_en && fif.fl_to_status) begin
			// affected bits ignore the written value
			flags_d = (fif.fl_result[`IAF_FLAG_W-1:0] & ~fif.fl_mask)
				| (fif.fl_alu & fif.fl_mask);
		end else if (fif.fl_alu_en) begin
			flags_d = (flags_q & ~fif.fl_mask) | (fif.fl_alu & fif.fl_mask);
		end else if (fif.fl_sw_en) begin
			flags_d = fif.fl_sw_data;
		end
		if (fif.fl_z_set) begin
			flags_d[`IAF_FB_Z] = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			flags_q <= `IAF_FLAG_RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign fif.fl_val = flags_q;
endmodule : iaf_flag_unit

/* tb/iaf_core_chk.sv */
// Purpose: port-level assertions for iaf_core
// Assumes: one clock, synchronous reset high
// Notes:   bound to iaf_core below the module
`timescale 1ns/1ps
`include "iaf_cfg.svh"
module iaf_core_chk (
	input wire logic                     core_clk,      // clock
	input wire logic                     rst,           // reset
	input wire logic [3:0]               reg_addr,      // reg offset
	input wire logic [7:0]               reg_wdata,     // reg wdata
	input wire logic                     reg_wr,        // reg write
	input wire logic                     reg_rd,        // reg read
	input wire logic [7:0]               reg_rdata,     // reg rdata
	input wire logic                     ind_req,       // indirect req
	input wire logic [1:0]               ind_sel,       // pointer
	input wire iaf_pkg::iaf_mode_t       ind_mode,      // access mode
	input wire logic                     ind_wr,        // write
	input wire logic [7:0]               ind_wdata,     // write data
	input wire logic [11:0]              mem_addr,      // mem address
	input wire logic                     mem_re,        // mem read
	input wire logic                     mem_we,        // mem write
	input wire logic [7:0]               mem_wdata,     // mem wdata
	input wire logic                     ind_null,      // virtual hit
	input wire logic                     alu_go,        // alu pulse
	input wire iaf_pkg::iaf_op_t         alu_op,        // alu op
	input wire logic [7:0]               alu_a,         // operand a
	input wire logic [7:0]               alu_b,         // operand b
	input wire logic                     alu_to_status, // to status
	input wire logic [7:0]               alu_result,    // result
	input wire logic [4:0]               alu_flags      // flags
);
	import iaf_pkg::*;
	logic [7:0] a_q;
	logic [7:0] b_q;
	logic       quiet;
	assign quiet = !alu_go && !reg_wr;
	always_ff @(posedge core_clk) begin
		a_q <= alu_a;
		b_q <= alu_b;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence inc_rd;
		ind_req && !ind_wr && ind_mode == IAF_M_INC_AFTER && !reg_wr;
	endsequence
	a_status_hi: assert property (reg_rd && reg_addr == `IAF_OFS_STATUS
		|=> reg_rdata[7:5] == 3'h0) else $error("status top bits set");
	a_ind_flags: assert property (ind_req && quiet |=> alu_flags ==
		((ind_null && !$past(ind_wr)) ? ($past(alu_flags) | 5'h04)
		: $past(alu_flags))) else $error("pointer access moved flags");
	a_null_quiet: assert property (ind_null |-> !mem_re && !mem_we)
		else $error("memory strobe on virtual access");
	a_read_path: assert property (ind_req && !ind_wr |=> mem_re != ind_null)
		else $error("read neither memory nor virtual");
	a_idle_quiet: assert property (!ind_req |=> !mem_re && !mem_we && !ind_null)
		else $error("strobe without request");
	a_inc_step: assert property (inc_rd ##1 (inc_rd and $stable(ind_sel)
		and mem_re) |=> mem_addr == $past(mem_addr) + 12'h001)
		else $error("post increment step wrong");
	a_dec_step: assert property (ind_req && !ind_wr &&
		ind_mode == IAF_M_DEC_AFTER && !reg_wr ##1 ind_req && !ind_wr &&
		ind_mode == IAF_M_DEC_AFTER && $stable(ind_sel) && !reg_wr && mem_re
		|=> mem_addr + 12'h001 == $past(mem_addr))
		else $error("post decrement step wrong");
	a_add_sum: assert property (alu_go && alu_op == IAF_OP_ADD |=>
		{alu_flags[0], alu_result} == {1'b0, a_q} + {1'b0, b_q} &&
		alu_flags[1] == (a_q[3:0] + b_q[3:0] > 15))
		else $error("add carry wrong");
	a_sub_borrow: assert property (alu_go && alu_op == IAF_OP_SUB |=>
		{alu_flags[0], alu_result} == {1'b0, a_q} + {1'b0, ~b_q} + 9'h001)
		else $error("subtract borrow wrong");
	a_ovf_sign: assert property (alu_go && alu_op == IAF_OP_ADD |=>
		alu_flags[3] == (a_q[7] == b_q[7] && alu_result[7] != a_q[7]))
		else $error("overflow wrong");
	a_neg_zero: assert property (alu_go && alu_op == IAF_OP_OR &&
		!alu_to_status && !ind_req |=> alu_flags[4] == alu_result[7] &&
		alu_flags[2] == (alu_result == 8'h00)) else $error("n or z wrong");
	a_rot_carry: assert property (alu_go && alu_op == IAF_OP_RRC &&
		!alu_to_status |=> alu_flags[1:0] == {a_q[4], a_q[0]})
		else $error("rotate carry wrong");
	a_clr_status: assert property (alu_go && alu_op == IAF_OP_CLR &&
		alu_to_status && !ind_req |=> alu_flags == 5'h04)
		else $error("status write not masked");
	c_null: cover property (ind_null);
	c_to_status: cover property (alu_go && alu_to_status);
	c_burst: cover property (ind_req ##1 ind_req);
endmodule : iaf_core_chk

bind iaf_core iaf_core_chk iaf_core_chk_inst (.core_clk, .rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ind_req, .ind_sel, .ind_mode,
	.ind_wr, .ind_wdata, .mem_addr, .mem_re, .mem_we, .mem_wdata, .ind_null,
	.alu_go, .alu_op, .alu_a, .alu_b, .alu_to_status, .alu_result,
	.alu_flags);

/* tb/iaf_mem_model.sv */
// Purpose: data memory seen through the indirect port
// Assumes: write strobe is a one-cycle pulse
// Notes:   keeps the last write for the bench to judge
`timescale 1ns/1ps
module iaf_mem_model (
	input  wire logic        core_clk,   // clock
	input  wire logic [11:0] mem_addr,   // address
	input  wire logic        mem_we,     // write strobe
	input  wire logic [7:0]  mem_wdata,  // write data
	output logic [11:0]      last_waddr, // last written address
	output logic [7:0]       last_wdata  // last written data
);
	logic [7:0] ram [4096];
	initial begin
		last_waddr = 12'h000;
		last_wdata = 8'h00;
	end
	always @(posedge core_clk) begin
		if (mem_we) begin
			ram[mem_addr] <= mem_wdata;
			last_waddr <= mem_addr;
			last_wdata <= mem_wdata;
		end
	end
endmodule : iaf_mem_model

/* tb/iaf_core_bench.sv */
// Purpose: self-checking bench for iaf_core
// Assumes: 40 MHz core clock, reset 6 cycles
// Notes:   expectations worked out by hand per scenario
`timescale 1ns/1ps
`include "iaf_cfg.svh"
module iaf_core_bench;
	import iaf_pkg::*;
	logic core_clk, rst, reg_wr, reg_rd, ind_req, ind_wr, mem_re, mem_we;
	logic ind_null, alu_go, alu_to_status;
	logic [3:0] reg_addr;
	logic [1:0] ind_sel;
	logic [11:0] mem_addr, last_waddr;
	logic [7:0] reg_wdata, reg_rdata, ind_wdata, mem_wdata, alu_a, alu_b;
	logic [7:0] alu_result, last_wdata;
	logic [4:0] alu_flags;
	iaf_mode_t ind_mode;
	iaf_op_t alu_op;
	int n_mismatch = 0;
	int checks = 0;

	iaf_core iaf_core_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .ind_req, .ind_sel, .ind_mode, .ind_wr,
		.ind_wdata, .mem_addr, .mem_re, .mem_we, .mem_wdata, .ind_null,
		.alu_go, .alu_op, .alu_a, .alu_b, .alu_to_status, .alu_result,
		.alu_flags);
	iaf_mem_model iaf_mem_model_inst (.core_clk, .mem_addr, .mem_we,
		.mem_wdata, .last_waddr, .last_wdata);

	task automatic report_and_stop;
		if (n_mismatch == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	task automatic cmp_val(input logic [11:0] got, exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp_val

	// strobe set is {mem_re, mem_we, ind_null}
	task automatic cmp_strb(input logic [2:0] exp);
		checks++;
		if ({mem_re, mem_we, ind_null} !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t strobes exp %b", $time, exp);
		end
	endtask : cmp_strb

	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : bus_wr

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		cmp_val({4'h0, reg_rdata}, {4'h0, exp}, "reg read");
	endtask : rd_chk

	task automatic set_ptr(input logic [1:0] i, input logic [11:0] v);
		bus_wr({1'b0, i, 1'b0}, v[7:0]);
		bus_wr({1'b0, i, 1'b1}, {4'h0, v[11:8]});
	endtask : set_ptr

	task automatic ptr_chk(input logic [1:0] i, input logic [11:0] v);
		rd_chk({1'b0, i, 1'b0}, v[7:0]);
		rd_chk({1'b0, i, 1'b1}, {4'h0, v[11:8]});
	endtask : ptr_chk

	task automatic ind_do(input logic [1:0] s, input iaf_mode_t m,
		input logic w, input logic [7:0] d, input int n,
		input logic [11:0] ea, step, input logic [2:0] es);
		@(posedge core_clk);
		ind_sel <= s;
		ind_mode <= m;
		ind_wr <= w;
		ind_wdata <= d;
		ind_req <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			if (i == n - 1) ind_req <= 1'b0;
			#1;
			cmp_strb(es);
			if (es[2:1] != 2'b00) cmp_val(mem_addr, 12'(ea + step * i), "addr");
		end
	endtask : ind_do

	task automatic alu_do(input iaf_op_t op, input logic [7:0] a, b,
		input logic ts, input logic [7:0] er, input logic [4:0] ef);
		@(posedge core_clk);
		alu_op <= op;
		alu_a <= a;
		alu_b <= b;
		alu_to_status <= ts;
		alu_go <= 1'b1;
		@(posedge core_clk);
		alu_go <= 1'b0;
		#1;
		cmp_val({4'h0, alu_result}, {4'h0, er}, "alu result");
		cmp_val({7'h0, alu_flags}, {7'h0, ef}, "alu flags");
	endtask : alu_do

	task automatic s_regs;
		rd_chk(`IAF_OFS_STATUS, 8'h00);
		bus_wr(`IAF_OFS_STATUS, 8'hFF);
		rd_chk(`IAF_OFS_STATUS, 8'h1F);
		set_ptr(2'd1, 12'hABC);
		bus_wr(`IAF_OFS_PTR1H, 8'hFA);
		ptr_chk(2'd1, 12'hABC);
		rd_chk(4'hB, 8'h00);
	endtask : s_regs

	task automatic s_modes;
		bus_wr(`IAF_OFS_STATUS, 8'h0A);
		bus_wr(`IAF_OFS_WORKING_REG, 8'hFE);
		set_ptr(2'd0, 12'h0FF);
		ind_do(0, IAF_M_INC_AFTER, 0, 0, 2, 12'h0FF, 1, 3'b100);
		ptr_chk(2'd0, 12'h101);
		ind_do(0, IAF_M_DEC_AFTER, 0, 0, 2, 12'h101, 12'hFFF, 3'b100);
		ptr_chk(2'd0, 12'h0FF);
		ind_do(0, IAF_M_INC_BEFORE, 0, 0, 1, 12'h100, 0, 3'b100);
		ind_do(0, IAF_M_PLAIN, 0, 0, 1, 12'h100, 0, 3'b100);
		ind_do(0, IAF_M_INDEXED, 0, 0, 1, 12'h0FE, 0, 3'b100);
		ptr_chk(2'd0, 12'h100);
		rd_chk(`IAF_OFS_WORKING_REG, 8'hFE);
		set_ptr(2'd2, 12'hFFF);
		ind_do(2, IAF_M_INC_AFTER, 1, 8'h3C, 1, 12'hFFF, 0, 3'b010);
		ptr_chk(2'd2, 12'h000);
		rd_chk(`IAF_OFS_MADDRL, 8'hFF);
		rd_chk(`IAF_OFS_MADDRH, 8'h0F);
		cmp_val(last_waddr, 12'hFFF, "mem addr");
		cmp_val({4'h0, last_wdata}, 12'h03C, "mem data");
		cmp_val({7'h0, alu_flags}, 12'h00A, "flags kept");
	endtask : s_modes

	task automatic s_virtual;
		set_ptr(2'd1, 12'hFE4);
		ind_do(1, IAF_M_PLAIN, 0, 0, 1, 0, 0, 3'b001);
		ind_do(1, IAF_M_PLAIN, 1, 8'h77, 1, 0, 0, 3'b001);
		rd_chk(`IAF_OFS_STATUS, 8'h0E);
		cmp_val({4'h0, last_wdata}, 12'h03C, "no mem write");
	endtask : s_virtual

	task automatic s_ptr_byte;
		set_ptr(2'd0, 12'hFD8);
		ind_do(0, IAF_M_INC_AFTER, 1, 8'h55, 1, 0, 0, 3'b000);
		ptr_chk(2'd0, 12'hF55);
	endtask : s_ptr_byte

	task automatic s_alu;
		alu_do(IAF_OP_ADD, 8'h7F, 8'h01, 0, 8'h80, 5'h1A);
		alu_do(IAF_OP_SUB, 8'h05, 8'h05, 0, 8'h00, 5'h07);
		alu_do(IAF_OP_SUB, 8'h00, 8'h01, 0, 8'hFF, 5'h10);
		alu_do(IAF_OP_RRC, 8'h11, 8'h00, 0, 8'h08, 5'h03);
		alu_do(IAF_OP_RLC, 8'h88, 8'h00, 0, 8'h11, 5'h03);
		alu_do(IAF_OP_RRNC, 8'h01, 8'h00, 0, 8'h80, 5'h11);
		alu_do(IAF_OP_RLNC, 8'h08, 8'h00, 0, 8'h10, 5'h03);
		alu_do(IAF_OP_CLR, 8'h55, 8'h00, 0, 8'h00, 5'h07);
		alu_do(IAF_OP_AND, 8'hF0, 8'h0F, 0, 8'h00, 5'h07);
		alu_do(IAF_OP_OR, 8'h80, 8'h01, 0, 8'h81, 5'h13);
		alu_do(IAF_OP_XOR, 8'h81, 8'h81, 0, 8'h00, 5'h07);
		alu_do(IAF_OP_MOV, 8'h80, 8'h00, 0, 8'h80, 5'h13);
		alu_do(IAF_OP_CLR, 8'h00, 8'h00, 1, 8'h00, 5'h04);
		rd_chk(`IAF_OFS_STATUS, 8'h04);
		rd_chk(`IAF_OFS_ALURES, 8'h00);
	endtask : s_alu

	task automatic s_reset;
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd_chk(`IAF_OFS_STATUS, 8'h00);
		ptr_chk(2'd1, 12'h000);
		rd_chk(`IAF_OFS_MADDRL, 8'h00);
	endtask : s_reset

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		$display("CHECK FAILED %0t run too long", $time);
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, ind_req, ind_wr, alu_go, alu_to_status} = 6'h00;
		{reg_addr, reg_wdata, ind_sel, ind_wdata, alu_a, alu_b} = 38'h0;
		ind_mode = IAF_M_PLAIN;
		alu_op = IAF_OP_ADD;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		s_regs();
		s_modes();
		s_virtual();
		s_ptr_byte();
		s_alu();
		s_reset();
		report_and_stop();
	end
endmodule : iaf_core_bench
